// >>> hdl/dpc_leads.sv
`timescale 1ns/1ps
// Behaviour
// RL1: Transmit clock output inverted when inversion enabled, normal otherwise.
// RL2: Loop permission setting selects none, local, remote or both DTE loops.
// RL3: Local loop held while DTE local loop lead on; terminal abort ignored.
// RL4: Remote loop lead permitted sends in-band V.54 loop sequence to line.
// RL5: Bilateral mode adds local loop during DSU loopback, ending with it.
// RL6: Bilateral loop starts by management command or V.54 Loop 2 Up.
// RL7: Constant carrier forces internal RTS on; line sends data, or the V.54 loop sequence.
// RL8: Switched carrier sends control idle codes while external RTS off.
// RL9: Carrier selection changes only while in-band management channel off.
// RL10: Standard CTS follows delayed internal RTS, off on alarm or test.
// RL11: Follow-RTS CTS tracks external RTS directly, ignoring alarms and tests.
// RL12: Forced-on CTS asserted after power-up with passing self-test.
// RL13: Circuit assurance CTS as standard, also off on received control idle.
// RL14: Standard RLSD on with receive data mode; off on alarm or idle.
// RL15: Forced-on RLSD asserted after power-up with passing self-test.
// RL16: Standard DSR on except during facility alarm or test mode.
// RL17: Forced-on DSR asserted after power-up with passing self-test.
// RL18: On-during-test DSR as standard but stays on during test.
// RL19: DTR monitoring reports link up and down events with health message.
// RL20: DTR monitoring disabled ignores DTR completely.
// RL21: Carrier selection defaults constant; switched is only alternative.
// RL22: CTS modes standard, follow, forced, assurance; default standard.
// RL23: Reset disables inversion, loops, bilateral; standard RLSD/DSR; DTR monitored.
module dpc_leads (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic selftest_pass_i,
    input wire logic cfg_we_i,
    input wire logic cfg_inv_txclk_i,
    input wire dpc_pkg::dpc_lb_perm_t cfg_lb_perm_i,
    input wire logic cfg_bilateral_i,
    input wire logic cfg_carrier_i,
    input wire dpc_pkg::dpc_cts_mode_t cfg_cts_mode_i,
    input wire logic cfg_rlsd_mode_i,
    input wire dpc_pkg::dpc_dsr_mode_t cfg_dsr_mode_i,
    input wire logic cfg_dtr_mon_i,
    input wire logic inband_mgmt_channel_en_i,
    input wire logic link_clk_i,
    input wire logic rts_i,
    input wire logic dtr_i,
    input wire logic local_loop_i,
    input wire logic remote_loop_i,
    input wire logic alarm_i,
    input wire logic test_active_i,
    input wire logic rx_data_mode_i,
    input wire logic rx_ctrl_idle_i,
    input wire logic dsu_loop_active_i,
    input wire logic network_manager_bilat_i,
    input wire logic v54_loop2_up_i,
    input wire logic ascii_terminal_interface_abort_i,
    output logic txclk_o,
    output logic cts_o,
    output logic dsr_o,
    output logic rlsd_o,
    output logic local_loop_o,
    output logic v54_send_o,
    output dpc_pkg::dpc_tx_sel_t tx_sel_o,
    output logic link_up_o,
    output logic link_down_o,
    output logic health_msg_o,
    output logic carrier_sw_o
);
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pins_s;
    logic clk_s;
    logic rts_s;
    logic dtr_s;
    logic ll_s;
    logic rl_s;
    logic inv_q;
    dpc_pkg::dpc_lb_perm_t perm_q;
    logic bilat_q;
    logic carrier_q;
    dpc_pkg::dpc_cts_mode_t cts_mode_q;
    logic rlsd_mode_q;
    dpc_pkg::dpc_dsr_mode_t dsr_mode_q;
    logic dtr_mon_q;
    logic ready_q;
    logic bilat_loop_q;
    logic dtr_prev_q;
    logic rts_int;
    logic rts_del;
    logic ll_ok;
    logic rl_ok;
    logic cts_std;
    logic cts_d;
    logic dsr_d;
    logic rlsd_d;
    dpc_pkg::dpc_tx_sel_t tx_sel_d;

    // DTE pins are asynchronous here; nothing reads the first stage
    dpc_sync #(
        .W(NSYNC)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({link_clk_i, rts_i, dtr_i, local_loop_i, remote_loop_i}),
        .q_o(pins_s)
    );
    assign {clk_s, rts_s, dtr_s, ll_s, rl_s} = pins_s;

    // RL23 reset defaults
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            inv_q <= 1'b0;
        end else if (cfg_we_i) begin
            inv_q <= cfg_inv_txclk_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            perm_q <= dpc_pkg::DPC_LB_NONE;
        end else if (cfg_we_i) begin
            perm_q <= cfg_lb_perm_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bilat_q <= 1'b0;
        end else if (cfg_we_i) begin
            bilat_q <= cfg_bilateral_i;
        end
    end

    // RL22 four CTS modes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cts_mode_q <= dpc_pkg::DPC_CTS_STANDARD;
        end else if (cfg_we_i) begin
            cts_mode_q <= cfg_cts_mode_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rlsd_mode_q <= dpc_pkg::DPC_RLSD_STANDARD;
        end else if (cfg_we_i) begin
            rlsd_mode_q <= cfg_rlsd_mode_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dsr_mode_q <= dpc_pkg::DPC_DSR_STANDARD;
        end else if (cfg_we_i) begin
            dsr_mode_q <= cfg_dsr_mode_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dtr_mon_q <= 1'b1;
        end else if (cfg_we_i) begin
            dtr_mon_q <= cfg_dtr_mon_i;
        end
    end

    // RL21 default constant carrier
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carrier_q <= dpc_pkg::DPC_CARRIER_CONSTANT;
        // RL9 locked while channel enabled
        end else if (cfg_we_i && !inband_mgmt_channel_en_i) begin
            carrier_q <= cfg_carrier_i;
        end
    end

    // Forced-on modes wait for self-test to pass
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b0;
        end else if (selftest_pass_i) begin
            ready_q <= 1'b1;
        end
    end

    // RL1 clock polarity
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            txclk_o <= 1'b0;
        end else begin
            txclk_o <= clk_s ^ inv_q;
        end
    end

    // RL2 permission decode
    assign ll_ok = (perm_q == dpc_pkg::DPC_LB_LOCAL) || (perm_q == dpc_pkg::DPC_LB_BOTH);
    assign rl_ok = (perm_q == dpc_pkg::DPC_LB_REMOTE) || (perm_q == dpc_pkg::DPC_LB_BOTH);

    // RL6 bilateral start sources
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bilat_loop_q <= 1'b0;
        end else if (!bilat_q) begin
            bilat_loop_q <= 1'b0;
        end else if (network_manager_bilat_i || v54_loop2_up_i) begin
            bilat_loop_q <= 1'b1;
        // RL5 ends with DSU loopback
        end else if (!dsu_loop_active_i) begin
            bilat_loop_q <= 1'b0;
        end
    end

    // RL3 abort input has no effect on the DTE loop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            local_loop_o <= 1'b0;
        end else begin
            // RL5 local loop accompanies DSU loop
            local_loop_o <= (ll_ok && ll_s) || (bilat_q && (bilat_loop_q || dsu_loop_active_i));
        end
    end

    // RL4 remote loop sequence
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            v54_send_o <= 1'b0;
        end else begin
            v54_send_o <= rl_ok && rl_s;
        end
    end

    // RL7 internal RTS forced on in constant mode
    assign rts_int = (carrier_q == dpc_pkg::DPC_CARRIER_CONSTANT) ? 1'b1 : rts_s;

    always_comb begin
        if (v54_send_o) begin
            tx_sel_d = dpc_pkg::DPC_TX_V54_LOOP;
        // RL8 control idle while RTS off
        end else if (!rts_int) begin
            tx_sel_d = dpc_pkg::DPC_TX_CTRL_IDLE;
        end else begin
            tx_sel_d = dpc_pkg::DPC_TX_DATA;
        end
    end

    // Ones idle only while held in reset, before any RTS state is known
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_sel_o <= dpc_pkg::DPC_TX_IDLE_ONES;
        end else begin
            tx_sel_o <= tx_sel_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carrier_sw_o <= dpc_pkg::DPC_CARRIER_CONSTANT;
        end else begin
            carrier_sw_o <= carrier_q;
        end
    end

    dpc_delay u_cts_delay (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(rts_int),
        .q_o(rts_del)
    );

    // RL10 standard gating
    assign cts_std = rts_del && !alarm_i && !test_active_i;

    always_comb begin
        case (cts_mode_q)
            dpc_pkg::DPC_CTS_STANDARD: cts_d = cts_std;
            // RL11 no delay, no gating
            dpc_pkg::DPC_CTS_FOLLOW_RTS: cts_d = rts_s;
            // RL12 forced on
            dpc_pkg::DPC_CTS_FORCED_ON: cts_d = ready_q;
            // RL13 also off on control idle
            dpc_pkg::DPC_CTS_ASSURANCE: cts_d = cts_std && !rx_ctrl_idle_i;
            default: cts_d = cts_std;
        endcase
    end

    always_comb begin
        // RL14 standard detector
        rlsd_d = rx_data_mode_i && !alarm_i && !rx_ctrl_idle_i;
        // RL15 forced on
        if (rlsd_mode_q == dpc_pkg::DPC_RLSD_FORCED_ON) begin
            rlsd_d = ready_q;
        end
    end

    always_comb begin
        case (dsr_mode_q)
            // RL16 off on alarm or test
            dpc_pkg::DPC_DSR_STANDARD: dsr_d = !alarm_i && !test_active_i;
            // RL17 forced on
            dpc_pkg::DPC_DSR_FORCED_ON: dsr_d = ready_q;
            // RL18 stays on in test
            dpc_pkg::DPC_DSR_ON_TEST: dsr_d = !alarm_i;
            default: dsr_d = !alarm_i && !test_active_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cts_o <= 1'b0;
        end else begin
            cts_o <= cts_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dsr_o <= 1'b0;
        end else begin
            dsr_o <= dsr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rlsd_o <= 1'b0;
        end else begin
            rlsd_o <= rlsd_d;
        end
    end

    // Previous DTR level, reset low like the synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dtr_prev_q <= 1'b0;
        end else begin
            dtr_prev_q <= dtr_s;
        end
    end

    // RL19 DTR edge events
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            link_up_o <= 1'b0;
            link_down_o <= 1'b0;
            health_msg_o <= 1'b0;
        end else begin
            // RL20 disabled means no events at all
            link_up_o <= dtr_mon_q && dtr_s && !dtr_prev_q;
            link_down_o <= dtr_mon_q && !dtr_s && dtr_prev_q;
            health_msg_o <= dtr_mon_q && (dtr_s != dtr_prev_q);
        end
    end
endmodule // dpc_leads

// >>> hdl/dpc_pkg.sv
package dpc_pkg;
    typedef enum logic [1:0] {
        DPC_LB_NONE,
        DPC_LB_LOCAL,
        DPC_LB_REMOTE,
        DPC_LB_BOTH
    } dpc_lb_perm_t;
    typedef enum logic [1:0] {
        DPC_CTS_STANDARD,
        DPC_CTS_FOLLOW_RTS,
        DPC_CTS_FORCED_ON,
        DPC_CTS_ASSURANCE
    } dpc_cts_mode_t;
    typedef enum logic [1:0] {
        DPC_DSR_STANDARD,
        DPC_DSR_FORCED_ON,
        DPC_DSR_ON_TEST
    } dpc_dsr_mode_t;
    // Line transmit source selection
    typedef enum logic [1:0] {
        DPC_TX_DATA,
        DPC_TX_IDLE_ONES,
        DPC_TX_CTRL_IDLE,
        DPC_TX_V54_LOOP
    } dpc_tx_sel_t;
    localparam logic DPC_CARRIER_CONSTANT = 1'b0;
    localparam logic DPC_CARRIER_SWITCHED = 1'b1;
    localparam logic DPC_RLSD_STANDARD = 1'b0;
    localparam logic DPC_RLSD_FORCED_ON = 1'b1;
    // Fixed RTS to CTS delay
    localparam int DPC_CLK_HZ = 40000000;
    localparam int DPC_CTS_DELAY_US = 5;
    localparam int DPC_CTS_DELAY_CYC = (DPC_CTS_DELAY_US * (DPC_CLK_HZ / 1000000));
    localparam int DPC_CNT_W = 8;
    localparam logic [DPC_CNT_W-1:0] DPC_CTS_DELAY_CNT = DPC_CNT_W'(DPC_CTS_DELAY_CYC);
endpackage

// >>> hdl/dpc_sync.sv
`timescale 1ns/1ps
module dpc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // dpc_sync

// >>> hdl/dpc_delay.sv
`timescale 1ns/1ps
// Level follows input after a fixed count of stable cycles
module dpc_delay (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic [dpc_pkg::DPC_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            q_o <= 1'b0;
        end else if (d_i == q_o) begin
            cnt_q <= '0;
        end else if (cnt_q == dpc_pkg::DPC_CTS_DELAY_CNT - 1'b1) begin
            cnt_q <= '0;
            q_o <= d_i;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // dpc_delay

// >>> tb/dpc_leads_chk.sv
`timescale 1ns/1ps
module dpc_leads_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_we_i,
    input wire logic cfg_inv_txclk_i,
    input wire dpc_pkg::dpc_cts_mode_t cfg_cts_mode_i,
    input wire logic cfg_rlsd_mode_i,
    input wire dpc_pkg::dpc_dsr_mode_t cfg_dsr_mode_i,
    input wire logic cfg_dtr_mon_i,
    input wire logic inband_mgmt_channel_en_i,
    input wire logic link_clk_i,
    input wire logic rts_i,
    input wire logic alarm_i,
    input wire logic test_active_i,
    input wire logic rx_ctrl_idle_i,
    input wire logic txclk_o,
    input wire logic cts_o,
    input wire logic dsr_o,
    input wire logic rlsd_o,
    input wire logic link_up_o,
    input wire logic link_down_o,
    input wire logic carrier_sw_o
);
    logic inv_q;
    logic rlsd_q;
    logic dtr_q;
    logic rdy;
    logic [2:0] cnt_q;
    dpc_pkg::dpc_cts_mode_t cts_q;
    dpc_pkg::dpc_dsr_mode_t dsr_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow of the settings, so checks follow the live mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            inv_q <= 1'b0;
            rlsd_q <= dpc_pkg::DPC_RLSD_STANDARD;
            dtr_q <= 1'b1;
            cts_q <= dpc_pkg::DPC_CTS_STANDARD;
            dsr_q <= dpc_pkg::DPC_DSR_STANDARD;
        end else if (cfg_we_i) begin
            inv_q <= cfg_inv_txclk_i;
            rlsd_q <= cfg_rlsd_mode_i;
            dtr_q <= cfg_dtr_mon_i;
            cts_q <= cfg_cts_mode_i;
            dsr_q <= cfg_dsr_mode_i;
        end
    end
    // Synchronisers hold stale values just after reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    assign rdy = (cnt_q == 3'h7);
    chk_txclk_phase: assert property (
        (rdy && $stable(link_clk_i) && $stable(inv_q))[*3] |-> txclk_o == (link_clk_i ^ inv_q)
    ) else $error("transmit clock polarity wrong");
    chk_cts_std_off: assert property (
        rdy && cts_q == dpc_pkg::DPC_CTS_STANDARD && (alarm_i || test_active_i) |=> !cts_o
    ) else $error("clear to send on during alarm or test");
    chk_cts_follow: assert property (
        (rdy && cts_q == dpc_pkg::DPC_CTS_FOLLOW_RTS && $stable(rts_i))[*4] |-> cts_o == rts_i
    ) else $error("clear to send not tracking request");
    chk_cts_assure: assert property (
        rdy && cts_q == dpc_pkg::DPC_CTS_ASSURANCE && rx_ctrl_idle_i |=> !cts_o
    ) else $error("clear to send on during control idle");
    chk_dsr_std_off: assert property (
        rdy && dsr_q == dpc_pkg::DPC_DSR_STANDARD && (alarm_i || test_active_i) |=> !dsr_o
    ) else $error("data set ready on during alarm or test");
    chk_rlsd_std_off: assert property (
        rdy && rlsd_q == dpc_pkg::DPC_RLSD_STANDARD && (alarm_i || rx_ctrl_idle_i) |=> !rlsd_o
    ) else $error("carrier detect on during alarm or idle");
    chk_dtr_ignored: assert property (
        (!dtr_q)[*4] |-> !(link_up_o || link_down_o)
    ) else $error("link event while terminal ready unmonitored");
    chk_carrier_lock: assert property (
        (rdy && inband_mgmt_channel_en_i)[*2] |=> $stable(carrier_sw_o)
    ) else $error("carrier setting changed while locked");
endmodule // dpc_leads_chk

// >>> tb/dpc_dte_model.sv
`timescale 1ns/1ps
module dpc_dte_model (
    input wire logic clk_i,
    output logic link_clk_o,
    output logic rts_o,
    output logic dtr_o,
    output logic loop_o,
    output logic rloop_o
);
    // Free-running timing, phase unrelated to clk_i
    initial begin
        link_clk_o = 1'b0;
        #37;
        forever #100 link_clk_o = ~link_clk_o;
    end
    initial {rts_o, dtr_o, loop_o, rloop_o} = 4'h0;
    task automatic set(input logic [3:0] v);
        @(negedge clk_i);
        {rts_o, dtr_o, loop_o, rloop_o} = v;
    endtask
endmodule // dpc_dte_model

// >>> tb/dpc_leads_test.sv
`timescale 1ns/1ps
module dpc_leads_test;
    logic clk_i, rst_n_i, selftest_pass_i, cfg_we_i, cfg_inv_txclk_i, cfg_bilateral_i;
    logic cfg_carrier_i, cfg_rlsd_mode_i, cfg_dtr_mon_i, inband_mgmt_channel_en_i;
    logic link_clk_i, rts_i, dtr_i, local_loop_i, remote_loop_i, alarm_i, test_active_i;
    logic rx_data_mode_i, rx_ctrl_idle_i, dsu_loop_active_i, network_manager_bilat_i;
    logic v54_loop2_up_i, ascii_terminal_interface_abort_i, txclk_o, cts_o, dsr_o, rlsd_o;
    logic local_loop_o, v54_send_o, link_up_o, link_down_o, health_msg_o, carrier_sw_o;
    logic u, d, h;
    dpc_pkg::dpc_lb_perm_t cfg_lb_perm_i;
    dpc_pkg::dpc_cts_mode_t cfg_cts_mode_i;
    dpc_pkg::dpc_dsr_mode_t cfg_dsr_mode_i;
    dpc_pkg::dpc_tx_sel_t tx_sel_o;
    int n_mismatch = 0;
    int n_tests = 0;
    dpc_leads i_dut (.*);
    dpc_dte_model i_dte (.clk_i(clk_i), .link_clk_o(link_clk_i), .rts_o(rts_i), .dtr_o(dtr_i),
        .loop_o(local_loop_i), .rloop_o(remote_loop_i));
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Levels: alarm, test, control idle, data mode, DSU loop
    task automatic lv(input logic [4:0] v);
        {alarm_i, test_active_i, rx_ctrl_idle_i, rx_data_mode_i, dsu_loop_active_i} = v;
    endtask
    task automatic chk(input logic [1:0] g, input logic [1:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Flags f are inv, bilateral, carrier, rlsd mode, dtr monitor
    task automatic cfg(input logic [1:0] lb, ct, ds, input logic [4:0] f);
        {cfg_inv_txclk_i, cfg_bilateral_i, cfg_carrier_i, cfg_rlsd_mode_i, cfg_dtr_mon_i} = f;
        cfg_lb_perm_i = dpc_pkg::dpc_lb_perm_t'(lb);
        cfg_cts_mode_i = dpc_pkg::dpc_cts_mode_t'(ct);
        cfg_dsr_mode_i = dpc_pkg::dpc_dsr_mode_t'(ds);
        cfg_we_i = 1'b1;
        w(1);
        cfg_we_i = 1'b0;
        w(3);
    endtask
    task automatic watch();
        {u, d, h} = 3'h0;
        repeat (6) begin
            @(negedge clk_i);
            u = u | link_up_o;
            d = d | link_down_o;
            h = h | health_msg_o;
        end
    endtask
    task automatic t_cts();
        w(148);
        chk(cts_o, 2'h0);
        w(62);
        chk(cts_o, 2'h1);
        lv(5'h12);
        w(2);
        chk(cts_o, 2'h0);
        lv(5'h02);
        cfg(2'h0, 2'h3, 2'h0, 5'h01);
        lv(5'h06);
        w(2);
        chk(cts_o, 2'h0);
        lv(5'h12);
        cfg(2'h0, 2'h1, 2'h0, 5'h01);
        i_dte.set(4'h8);
        w(4);
        chk(cts_o, 2'h1);
        lv(5'h02);
        i_dte.set(4'h0);
        cfg(2'h0, 2'h2, 2'h0, 5'h01);
        chk(cts_o, 2'h1);
        $display("clear to send test done");
    endtask
    task automatic t_dsr();
        cfg(2'h0, 2'h0, 2'h0, 5'h01);
        chk({dsr_o, rlsd_o}, 2'h3);
        lv(5'h08);
        w(2);
        chk({dsr_o, cts_o}, 2'h0);
        chk(rlsd_o, 2'h0);
        cfg(2'h0, 2'h0, 2'h2, 5'h01);
        chk(dsr_o, 2'h1);
        lv(5'h1e);
        w(2);
        chk({dsr_o, rlsd_o}, 2'h0);
        cfg(2'h0, 2'h0, 2'h1, 5'h03);
        chk({dsr_o, rlsd_o}, 2'h3);
        lv(5'h02);
        $display("data set ready test done");
    endtask
    task automatic t_loop();
        for (int p = 0; p < 4; p++) begin
            cfg(p[1:0], 2'h0, 2'h0, 5'h01);
            i_dte.set(4'h3);
            w(4);
            ascii_terminal_interface_abort_i = 1'b1;
            w(1);
            ascii_terminal_interface_abort_i = 1'b0;
            w(1);
            chk({local_loop_o, v54_send_o}, {p[0], p[1]});
            chk(tx_sel_o, p[1] ? 2'h3 : 2'h0);
            i_dte.set(4'h0);
            w(4);
            chk({local_loop_o, v54_send_o}, 2'h0);
        end
        cfg(2'h0, 2'h0, 2'h0, 5'h09);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) cfg(2'h0, 2'h0, 2'h0, 5'h01);
            lv(5'h03);
            {network_manager_bilat_i, v54_loop2_up_i} = k[0] ? 2'h1 : 2'h2;
            w(1);
            {network_manager_bilat_i, v54_loop2_up_i} = 2'h0;
            w(2);
            chk(local_loop_o, {1'b0, k != 2});
            lv(5'h02);
            w(2);
            chk(local_loop_o, 2'h0);
        end
        $display("loopback test done");
    endtask
    task automatic t_dtr();
        i_dte.set(4'h4);
        watch();
        chk({u, h}, 2'h3);
        i_dte.set(4'h0);
        watch();
        chk({d, h}, 2'h3);
        cfg(2'h0, 2'h0, 2'h0, 5'h00);
        i_dte.set(4'h4);
        watch();
        chk({u | d, h}, 2'h0);
        i_dte.set(4'h0);
        $display("terminal ready test done");
    endtask
    task automatic t_car();
        cfg(2'h0, 2'h0, 2'h0, 5'h05);
        chk({carrier_sw_o, tx_sel_o == dpc_pkg::DPC_TX_CTRL_IDLE}, 2'h3);
        i_dte.set(4'h8);
        w(4);
        chk(tx_sel_o, 2'h0);
        inband_mgmt_channel_en_i = 1'b1;
        cfg(2'h0, 2'h0, 2'h0, 5'h01);
        chk(carrier_sw_o, 2'h1);
        inband_mgmt_channel_en_i = 1'b0;
        cfg(2'h0, 2'h0, 2'h0, 5'h01);
        chk(carrier_sw_o, 2'h0);
        i_dte.set(4'h0);
        for (int i = 0; i < 2; i++) begin
            cfg(2'h0, 2'h0, 2'h0, {i[0], 4'h1});
            @(posedge link_clk_i);
            w(4);
            chk(txclk_o, {1'b0, !i[0]});
        end
        $display("carrier and clock test done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        {rst_n_i, selftest_pass_i, cfg_we_i, cfg_inv_txclk_i, cfg_bilateral_i} = 5'h00;
        {cfg_carrier_i, cfg_rlsd_mode_i, inband_mgmt_channel_en_i} = 3'h0;
        network_manager_bilat_i = 1'b0;
        {v54_loop2_up_i, ascii_terminal_interface_abort_i} = 2'h0;
        cfg_dtr_mon_i = 1'b1;
        lv(5'h02);
        cfg_lb_perm_i = dpc_pkg::DPC_LB_NONE;
        cfg_cts_mode_i = dpc_pkg::DPC_CTS_STANDARD;
        cfg_dsr_mode_i = dpc_pkg::DPC_DSR_STANDARD;
        w(2);
        chk(tx_sel_o, 2'h1);
        {rst_n_i, selftest_pass_i} = 2'h3;
        w(1);
        selftest_pass_i = 1'b0;
        chk(carrier_sw_o, 2'h0);
        t_cts();
        t_dsr();
        t_loop();
        t_dtr();
        t_car();
        report_and_stop();
    end
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // dpc_leads_test
bind dpc_leads dpc_leads_chk i_chk (.*);
